// file: rtl/timer_core_pkg.sv
package timer_core_pkg;
   // Register offsets in data space
   localparam logic [7:0] OFS_SYNC_CTRL = 8'h43;
   localparam logic [7:0] OFS_FLAGS = 8'h37;
   localparam logic [7:0] OFS_MASK = 8'h70;
   localparam logic [7:0] OFS_CTRL_A = 8'hB0;
   localparam logic [7:0] OFS_CTRL_B = 8'hB1;
   localparam logic [7:0] OFS_COUNT = 8'hB2;
   localparam logic [7:0] OFS_CMP_A = 8'hB3;
   localparam logic [7:0] OFS_CMP_B = 8'hB4;
   localparam logic [7:0] OFS_ASYNC = 8'hB6;
   // Field positions
   localparam int POS_HOLD = 7;
   localparam int POS_PSR_ASYNC = 1;
   localparam int POS_PSR_SHARED = 0;
   localparam int POS_WAVE_TWO = 3;
   localparam int POS_ASYNC_SEL = 5;
   localparam int POS_OVF = 0;
   localparam int POS_CMP_A = 1;
   localparam int POS_CMP_B = 2;
   // Reset values and limits
   localparam logic [7:0] RST_VAL = 8'h00;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [9:0] PRE_RST = 10'h000;
   // Clock select codes
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIRECT = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   // Waveform modes
   localparam logic [2:0] WM_NORMAL = 3'h0;
   localparam logic [2:0] WM_PHASE_MAX = 3'h1;
   localparam logic [2:0] WM_CLEAR_CMP = 3'h2;
   localparam logic [2:0] WM_FAST_MAX = 3'h3;
   localparam logic [2:0] WM_PHASE_CMP = 3'h5;
   localparam logic [2:0] WM_FAST_CMP = 3'h7;
endpackage

// file: rtl/pin_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
module pin_edge_detect (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } edge_st_t;
   edge_st_t st_ff;
   edge_st_t nxt_st;

   always_comb begin
      nxt_st.s1 = pin;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rise = st_ff.s2 & ~st_ff.s3;
   assign fall = ~st_ff.s2 & st_ff.s3;
endmodule
`default_nettype wire

// file: rtl/prescaler10.sv
`timescale 1ns/1ns
`default_nettype none
module prescaler10 (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clr,
   input wire logic en,
   output logic tap8,
   output logic tap64,
   output logic tap256,
   output logic tap1024
);
   import timer_core_pkg::*;
   typedef struct packed {
      logic [9:0] cnt;
   } pre_st_t;
   pre_st_t st_ff;
   pre_st_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (clr) begin
         nxt_st.cnt = PRE_RST;
      end else if (en) begin
         nxt_st.cnt = st_ff.cnt + 10'h001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_ff.cnt <= PRE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Taps fire on the enable that wraps the low bits
   assign tap8 = en & ~clr & (&st_ff.cnt[2:0]);
   assign tap64 = en & ~clr & (&st_ff.cnt[5:0]);
   assign tap256 = en & ~clr & (&st_ff.cnt[7:0]);
   assign tap1024 = en & ~clr & (&st_ff.cnt[9:0]);
endmodule
`default_nettype wire

// file: rtl/timer_prescaler_counter_core.sv
`timescale 1ns/1ns
`default_nettype none
module timer_prescaler_counter_core (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   input wire logic ext_count_pin_zero,
   input wire logic crystal_pin_in,
   output logic crystal_pin_out,
   output logic [3:0] shared_taps,
   output logic [2:0] irq,
   output logic at_bottom,
   output logic at_max
);
   import timer_core_pkg::*;

   typedef struct packed {
      logic hold;
      logic psr_async;
      logic psr_shared;
      logic [1:0] wave_lo;
      logic wave_two;
      logic [2:0] cs;
      logic [7:0] cnt;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic async_sel;
      logic [2:0] flags;
      logic [2:0] mask;
      logic down;
      logic block;
      logic [7:0] rdata;
      logic [2:0] irq;
      logic bottom;
      logic maxv;
      logic xtal_out;
      logic xtal_s1;
      logic xtal_s2;
      logic [3:0] taps;
   } core_st_t;

   core_st_t st_ff;
   core_st_t nxt_st;

   logic pin_rise, pin_fall, xtal_rise;
   logic a8, a64, a256, a1024, s8, s64, s256, s1024;
   logic base_en, tick, wr_ctrl, wr_cnt;
   logic [2:0] wave_mode_field;
   logic [7:0] top_val;
   logic [2:0] set_flags;

   pin_edge_detect u_pin (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pin(ext_count_pin_zero),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   pin_edge_detect u_xtal (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pin(crystal_pin_in),
      .rise(xtal_rise),
      .fall()
   );

   prescaler10 u_pre_async (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clr(st_ff.psr_async),
      .en(base_en),
      .tap8(a8),
      .tap64(a64),
      .tap256(a256),
      .tap1024(a1024)
   );

   prescaler10 u_pre_shared (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clr(st_ff.psr_shared),
      .en(1'b1),
      .tap8(s8),
      .tap64(s64),
      .tap256(s256),
      .tap1024(s1024)
   );

   assign wr_ctrl = cpu_wr && (cpu_addr == OFS_SYNC_CTRL);
   assign wr_cnt = cpu_wr && (cpu_addr == OFS_COUNT);
   assign wave_mode_field = {st_ff.wave_two, st_ff.wave_lo};
   assign base_en = st_ff.async_sel ? xtal_rise : 1'b1;

   always_comb begin
      top_val = CNT_MAX;
      if (wave_mode_field == WM_CLEAR_CMP || wave_mode_field == WM_PHASE_CMP
          || wave_mode_field == WM_FAST_CMP) begin
         top_val = st_ff.cmp_a;
      end
   end

   always_comb begin
      case (st_ff.cs)
         CS_STOP: tick = 1'b0;
         CS_DIRECT: tick = base_en & ~st_ff.psr_async;
         CS_DIV8: tick = a8;
         CS_DIV64: tick = a64;
         CS_DIV256: tick = a256;
         CS_DIV1024: tick = a1024;
         CS_EXT_FALL: tick = pin_fall;
         CS_EXT_RISE: tick = pin_rise;
         default: tick = 1'b0;
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      set_flags = 3'h0;
      // Prescaler reset bits
      if (wr_ctrl) begin
         nxt_st.hold = cpu_wdata[POS_HOLD];
         nxt_st.psr_async = cpu_wdata[POS_PSR_ASYNC];
         nxt_st.psr_shared = cpu_wdata[POS_PSR_SHARED];
      end else if (!st_ff.hold) begin
         nxt_st.psr_shared = 1'b0;
         if (!st_ff.async_sel || base_en) begin
            nxt_st.psr_async = 1'b0;
         end
      end
      // Counter sequence on a tick
      if (tick) begin
         nxt_st.block = 1'b0;
         if (!st_ff.block && st_ff.cnt == st_ff.cmp_a) begin
            set_flags[POS_CMP_A] = 1'b1;
         end
         if (!st_ff.block && st_ff.cnt == st_ff.cmp_b) begin
            set_flags[POS_CMP_B] = 1'b1;
         end
         case (wave_mode_field)
            WM_CLEAR_CMP, WM_FAST_MAX, WM_FAST_CMP: begin
               if (st_ff.cnt == top_val) begin
                  nxt_st.cnt = CNT_BOTTOM;
               end else begin
                  nxt_st.cnt = st_ff.cnt + 8'h01;
               end
               if (wave_mode_field != WM_CLEAR_CMP
                   && st_ff.cnt == top_val) begin
                  set_flags[POS_OVF] = 1'b1;
               end
               if (wave_mode_field == WM_CLEAR_CMP && st_ff.cnt == CNT_MAX) begin
                  set_flags[POS_OVF] = 1'b1;
               end
            end
            WM_PHASE_MAX, WM_PHASE_CMP: begin
               if (!st_ff.down) begin
                  if (st_ff.cnt == top_val) begin
                     nxt_st.down = 1'b1;
                     nxt_st.cnt = st_ff.cnt - 8'h01;
                  end else begin
                     nxt_st.cnt = st_ff.cnt + 8'h01;
                  end
               end else begin
                  if (st_ff.cnt == CNT_BOTTOM) begin
                     nxt_st.down = 1'b0;
                     nxt_st.cnt = st_ff.cnt + 8'h01;
                     set_flags[POS_OVF] = 1'b1;
                  end else begin
                     nxt_st.cnt = st_ff.cnt - 8'h01;
                  end
               end
            end
            default: begin
               nxt_st.cnt = st_ff.cnt + 8'h01;
               if (st_ff.cnt == CNT_MAX) begin
                  set_flags[POS_OVF] = 1'b1;
               end
            end
         endcase
      end
      // CPU writes
      if (cpu_wr) begin
         case (cpu_addr)
            OFS_CTRL_A: nxt_st.wave_lo = cpu_wdata[1:0];
            OFS_CTRL_B: begin
               nxt_st.cs = cpu_wdata[2:0];
               nxt_st.wave_two = cpu_wdata[POS_WAVE_TWO];
            end
            OFS_COUNT: begin
               nxt_st.cnt = cpu_wdata;
               nxt_st.block = 1'b1;
            end
            OFS_CMP_A: nxt_st.cmp_a = cpu_wdata;
            OFS_CMP_B: nxt_st.cmp_b = cpu_wdata;
            OFS_ASYNC: nxt_st.async_sel = cpu_wdata[POS_ASYNC_SEL];
            OFS_MASK: nxt_st.mask = cpu_wdata[2:0];
            default: nxt_st.mask = st_ff.mask;
         endcase
      end
      // Flags: write one clears, a new event wins
      if (cpu_wr && cpu_addr == OFS_FLAGS) begin
         nxt_st.flags = (st_ff.flags & ~cpu_wdata[2:0]) | set_flags;
      end else begin
         nxt_st.flags = st_ff.flags | set_flags;
      end
      nxt_st.irq = st_ff.flags & st_ff.mask;
      nxt_st.bottom = (st_ff.cnt == CNT_BOTTOM);
      nxt_st.maxv = (st_ff.cnt == CNT_MAX);
      // Crystal pin passes two flops before the inverter
      nxt_st.xtal_s1 = crystal_pin_in;
      nxt_st.xtal_s2 = st_ff.xtal_s1;
      nxt_st.xtal_out = ~st_ff.xtal_s2;
      nxt_st.taps = {s1024, s256, s64, s8};
      // Read data
      case (cpu_addr)
         OFS_SYNC_CTRL: nxt_st.rdata = {st_ff.hold, 5'h00, st_ff.psr_async,
                                        st_ff.psr_shared};
         OFS_CTRL_A: nxt_st.rdata = {6'h00, st_ff.wave_lo};
         OFS_CTRL_B: nxt_st.rdata = {4'h0, st_ff.wave_two, st_ff.cs};
         OFS_COUNT: nxt_st.rdata = st_ff.cnt;
         OFS_CMP_A: nxt_st.rdata = st_ff.cmp_a;
         OFS_CMP_B: nxt_st.rdata = st_ff.cmp_b;
         OFS_ASYNC: nxt_st.rdata = {2'h0, st_ff.async_sel, 5'h00};
         OFS_FLAGS: nxt_st.rdata = {5'h00, st_ff.flags};
         OFS_MASK: nxt_st.rdata = {5'h00, st_ff.mask};
         default: nxt_st.rdata = RST_VAL;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign cpu_rdata = st_ff.rdata;
   assign crystal_pin_out = st_ff.xtal_out;
   assign shared_taps = st_ff.taps;
   assign irq = st_ff.irq;
   assign at_bottom = st_ff.bottom;
   assign at_max = st_ff.maxv;

   property p_write_wins;
      @(posedge core_clk) disable iff (sys_rst)
      wr_cnt |=> st_ff.cnt == $past(cpu_wdata);
   endproperty
   a_write_wins: assert property (p_write_wins)
      else $error("counter write lost");

   property p_stopped;
      @(posedge core_clk) disable iff (sys_rst)
      (st_ff.cs == CS_STOP && !wr_cnt) |=> $stable(st_ff.cnt);
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("counter moved while stopped");

   property p_hold_keeps;
      @(posedge core_clk) disable iff (sys_rst)
      (st_ff.hold && !wr_ctrl)
         |=> $stable({st_ff.psr_async, st_ff.psr_shared});
   endproperty
   a_hold_keeps: assert property (p_hold_keeps)
      else $error("reset bits changed under hold");

   property p_release;
      @(posedge core_clk) disable iff (sys_rst)
      (!st_ff.hold && !wr_ctrl) |=> !st_ff.psr_shared;
   endproperty
   a_release: assert property (p_release)
      else $error("shared reset bit not cleared");

   property p_async_sync_mode;
      @(posedge core_clk) disable iff (sys_rst)
      (!st_ff.hold && !wr_ctrl && !st_ff.async_sel) |=> !st_ff.psr_async;
   endproperty
   a_async_sync_mode: assert property (p_async_sync_mode)
      else $error("async reset bit not cleared");

   property p_async_pending;
      @(posedge core_clk) disable iff (sys_rst)
      (st_ff.async_sel && st_ff.psr_async && !base_en && !wr_ctrl)
         |=> st_ff.psr_async;
   endproperty
   a_async_pending: assert property (p_async_pending)
      else $error("async reset bit dropped early");

   property p_normal_wrap;
      @(posedge core_clk) disable iff (sys_rst)
      (tick && wave_mode_field == WM_NORMAL && st_ff.cnt == CNT_MAX && !wr_cnt)
         |=> (st_ff.cnt == CNT_BOTTOM) && st_ff.flags[POS_OVF];
   endproperty
   a_normal_wrap: assert property (p_normal_wrap)
      else $error("normal wrap wrong");

   property p_ctc_clear;
      @(posedge core_clk) disable iff (sys_rst)
      (tick && wave_mode_field == WM_CLEAR_CMP && st_ff.cnt == st_ff.cmp_a
       && !cpu_wr) |=> st_ff.cnt == CNT_BOTTOM;
   endproperty
   a_ctc_clear: assert property (p_ctc_clear)
      else $error("clear on compare missed");

   property p_cmp_flag;
      @(posedge core_clk) disable iff (sys_rst)
      (tick && !st_ff.block && st_ff.cnt == st_ff.cmp_b)
         |=> st_ff.flags[POS_CMP_B];
   endproperty
   a_cmp_flag: assert property (p_cmp_flag)
      else $error("compare flag b not set");

   property p_ext_rise;
      @(posedge core_clk) disable iff (sys_rst)
      (st_ff.cs == CS_EXT_RISE && pin_rise && wave_mode_field == WM_NORMAL
       && !wr_cnt) |=> st_ff.cnt == 8'($past(st_ff.cnt) + 8'h01);
   endproperty
   a_ext_rise: assert property (p_ext_rise)
      else $error("rising pin edge not counted");

   property p_irq_gate;
      @(posedge core_clk) disable iff (sys_rst)
      ##1 st_ff.irq == ($past(st_ff.flags) & $past(st_ff.mask));
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt gating wrong");

   property p_bottom;
      @(posedge core_clk) disable iff (sys_rst)
      (st_ff.cnt == CNT_BOTTOM) |=> at_bottom;
   endproperty
   a_bottom: assert property (p_bottom)
      else $error("bottom not signalled");
endmodule
`default_nettype wire

// file: testbench/count_source.sv
`timescale 1ns/1ns
`default_nettype none
module count_source (
   input wire logic core_clk,
   output logic pin,
   output logic xtal
);
   initial begin
      pin = 1'b0;
      xtal = 1'b0;
   end

   // Three cycles each phase, below clock over 2.5; rests low
   task pulses(input int n);
      for (int i = 0; i < n; i++) begin
         repeat (3) @(posedge core_clk);
         pin <= 1'b1;
         repeat (3) @(posedge core_clk);
         pin <= 1'b0;
      end
   endtask

   // Crystal runs only on request, else stands low
   task xtal_cycles(input int n);
      for (int i = 0; i < n; i++) begin
         repeat (4) @(posedge core_clk);
         xtal <= 1'b1;
         repeat (4) @(posedge core_clk);
         xtal <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// file: testbench/test_timer_prescaler_counter_core.sv
`timescale 1ns/1ns
`default_nettype none
module test_timer_prescaler_counter_core;
   import timer_core_pkg::*;
   logic core_clk, sys_rst, cpu_wr;
   logic [7:0] cpu_addr, cpu_wdata, cpu_rdata;
   logic ext_pin, xtal_in, xtal_out, at_bottom, at_max;
   logic [3:0] shared_taps;
   logic [2:0] irq;
   int error_cnt, checks_done, n, n64, n256;

   timer_prescaler_counter_core dut_u (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cpu_addr(cpu_addr),
      .cpu_wr(cpu_wr),
      .cpu_wdata(cpu_wdata),
      .cpu_rdata(cpu_rdata),
      .ext_count_pin_zero(ext_pin),
      .crystal_pin_in(xtal_in),
      .crystal_pin_out(xtal_out),
      .shared_taps(shared_taps),
      .irq(irq),
      .at_bottom(at_bottom),
      .at_max(at_max)
   );

   count_source src_u (
      .core_clk(core_clk),
      .pin(ext_pin),
      .xtal(xtal_in)
   );

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_wr <= 1'b1;
      @(posedge core_clk);
      cpu_wr <= 1'b0;
   endtask

   task rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      cpu_addr <= a;
      @(posedge core_clk);
      #1 chk(what, exp, cpu_rdata);
   endtask

   task settle;
      repeat (5) @(posedge core_clk);
   endtask

   task results;
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      error_cnt++;
      results;
   end

   initial begin
      sys_rst = 1'b1;
      cpu_wr = 1'b0;
      cpu_addr = 8'h00;
      cpu_wdata = 8'h00;
      error_cnt = 0;
      checks_done = 0;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd_chk("sync_ctrl", OFS_SYNC_CTRL, RST_VAL);
      settle;
      rd_chk("count_stopped", OFS_COUNT, CNT_BOTTOM);
      wr(8'h00, 8'hFF);
      rd_chk("unmapped", 8'h00, 8'h00);
      wr(OFS_COUNT, 8'hA5);
      rd_chk("count_rw", OFS_COUNT, 8'hA5);
      wr(OFS_CMP_A, 8'h5A);
      rd_chk("cmp_a_rw", OFS_CMP_A, 8'h5A);
      wr(OFS_CMP_B, 8'hC3);
      rd_chk("cmp_b_rw", OFS_CMP_B, 8'hC3);
      wr(OFS_COUNT, CNT_MAX);
      repeat (2) @(posedge core_clk);
      #1 chk("at_max", 8'h01, {7'h00, at_max});
      wr(OFS_COUNT, CNT_BOTTOM);
      repeat (2) @(posedge core_clk);
      #1 chk("at_bottom", 8'h01, {7'h00, at_bottom});
      wr(OFS_SYNC_CTRL, 8'h03);
      rd_chk("psr_self_clear", OFS_SYNC_CTRL, 8'h00);
      // Hold keeps both resets, prescalers and direct ticks frozen
      wr(OFS_SYNC_CTRL, 8'h83);
      wr(OFS_CTRL_B, {5'h00, CS_DIRECT});
      rd_chk("hold_keep", OFS_SYNC_CTRL, 8'h83);
      n = 0;
      repeat (20) begin
         @(posedge core_clk);
         #1 if (shared_taps !== 4'h0) n++;
      end
      chk("taps_held", 8'h00, n[7:0]);
      rd_chk("count_held", OFS_COUNT, CNT_BOTTOM);
      wr(OFS_SYNC_CTRL, 8'h00);
      rd_chk("hold_release", OFS_SYNC_CTRL, 8'h00);
      n = 0;
      while (shared_taps[0] !== 1'b1 && n < 12) begin
         @(posedge core_clk);
         #1 n++;
      end
      chk("tap8_resumed", 8'h01, {7'h00, shared_taps[0]});
      wr(OFS_MASK, 8'h01);
      n = 0;
      while (irq[0] !== 1'b1 && n < 300) begin
         @(posedge core_clk);
         #1 n++;
      end
      chk("ovf_irq", 8'h01, {7'h00, irq[0]});
      rd_chk("flags_all", OFS_FLAGS, 8'h07);
      wr(OFS_FLAGS, 8'h07);
      rd_chk("flags_cleared", OFS_FLAGS, 8'h00);
      wr(OFS_CTRL_B, {5'h00, CS_STOP});
      wr(OFS_MASK, 8'h00);
      wr(OFS_ASYNC, 8'h20);
      wr(OFS_SYNC_CTRL, 8'h02);
      rd_chk("async_psr_pending", OFS_SYNC_CTRL, 8'h02);
      src_u.xtal_cycles(4);
      rd_chk("async_psr_done", OFS_SYNC_CTRL, 8'h00);
      wr(OFS_ASYNC, 8'h00);
      #1 chk("xtal_out", 8'h01, {7'h00, xtal_out});
      // Pin rests low while selection changes
      wr(OFS_SYNC_CTRL, 8'h81);
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CTRL_B, {5'h00, CS_EXT_RISE});
      src_u.pulses(5);
      settle;
      rd_chk("ext_rise_held_psr", OFS_COUNT, 8'h05);
      wr(OFS_SYNC_CTRL, 8'h00);
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CTRL_B, {5'h00, CS_EXT_FALL});
      src_u.pulses(3);
      settle;
      rd_chk("ext_fall", OFS_COUNT, 8'h03);
      wr(OFS_COUNT, 8'hFE);
      wr(OFS_CTRL_B, {5'h00, CS_EXT_RISE});
      fork
         src_u.pulses(1);
         begin
            wait (ext_pin === 1'b1);
            n = 0;
            while (at_max !== 1'b1 && n < 10) begin
               @(posedge core_clk);
               #1 n++;
            end
         end
      join
      // At_max lags the counter by one cycle
      chk("ext_delay", 8'h01, {7'h00, (n == 4)});
      wr(OFS_CTRL_B, {5'h00, CS_STOP});
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CMP_A, 8'h05);
      wr(OFS_CMP_B, 8'h03);
      wr(OFS_CTRL_A, {6'h00, WM_CLEAR_CMP[1:0]});
      wr(OFS_FLAGS, 8'h07);
      wr(OFS_MASK, 8'h02);
      wr(OFS_CTRL_B, {5'h00, CS_EXT_RISE});
      src_u.pulses(5);
      settle;
      rd_chk("ctc_at_top", OFS_COUNT, 8'h05);
      rd_chk("flag_late", OFS_FLAGS, 8'h04);
      chk("irq_masked", 8'h00, {5'h00, irq});
      src_u.pulses(1);
      settle;
      rd_chk("ctc_clear", OFS_COUNT, 8'h00);
      rd_chk("flag_a_set", OFS_FLAGS, 8'h06);
      chk("irq_a", 8'h02, {5'h00, irq});
      wr(OFS_CTRL_B, {5'h00, CS_STOP});
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CMP_A, 8'h02);
      wr(OFS_CTRL_A, {6'h00, WM_FAST_CMP[1:0]});
      wr(OFS_CTRL_B, {4'h0, WM_FAST_CMP[2], CS_EXT_RISE});
      src_u.pulses(4);
      settle;
      rd_chk("fast_top_cmp", OFS_COUNT, 8'h01);
      // Shared prescaler taps keep their fixed rates
      n = 0;
      n64 = 0;
      n256 = 0;
      repeat (1024) begin
         @(posedge core_clk);
         #1;
         if (shared_taps[1] === 1'b1) n64++;
         if (shared_taps[2] === 1'b1) n256++;
         if (shared_taps[3] === 1'b1) n++;
      end
      chk("tap64_rate", 8'h10, n64[7:0]);
      chk("tap256_rate", 8'h04, n256[7:0]);
      chk("tap1024_rate", 8'h01, n[7:0]);
      // Up-down sequence with compare A as top
      wr(OFS_CTRL_B, {5'h00, CS_STOP});
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CMP_A, 8'h02);
      wr(OFS_CTRL_A, {6'h00, WM_PHASE_CMP[1:0]});
      wr(OFS_FLAGS, 8'h07);
      wr(OFS_CTRL_B, {4'h0, WM_PHASE_CMP[2], CS_EXT_RISE});
      src_u.pulses(4);
      settle;
      rd_chk("updown_fall", OFS_COUNT, 8'h00);
      rd_chk("updown_flags", OFS_FLAGS, 8'h02);
      src_u.pulses(1);
      settle;
      rd_chk("updown_bottom", OFS_COUNT, 8'h01);
      rd_chk("updown_ovf", OFS_FLAGS, 8'h03);
      // Divide-by-8 ticks start together on hold release
      wr(OFS_CTRL_B, {5'h00, CS_STOP});
      wr(OFS_CTRL_A, {6'h00, WM_NORMAL[1:0]});
      wr(OFS_COUNT, 8'h00);
      wr(OFS_SYNC_CTRL, 8'h82);
      wr(OFS_CTRL_B, {5'h00, CS_DIV8});
      wr(OFS_SYNC_CTRL, 8'h00);
      repeat (36) @(posedge core_clk);
      rd_chk("div8_count", OFS_COUNT, 8'h04);
      // Second reset in mid-run returns the block to idle
      wr(OFS_SYNC_CTRL, 8'h83);
      sys_rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd_chk("sync_ctrl_rerun", OFS_SYNC_CTRL, RST_VAL);
      rd_chk("count_rerun", OFS_COUNT, CNT_BOTTOM);
      results;
   end
endmodule
`default_nettype wire
